/* core/rpu_pkg.sv */
package rpu_pkg;

   // ----------------------------------------------------------------
   // register map and fields
   // ----------------------------------------------------------------
   localparam int NUM_REGIONS = 8;
   localparam logic [31:0] ADDR_INFO = 32'hE000ED90;
   localparam logic [31:0] ADDR_CTRL = 32'hE000ED94;
   localparam logic [31:0] ADDR_SELECT = 32'hE000ED98;
   localparam logic [31:0] ADDR_BASE = 32'hE000ED9C;
   localparam logic [31:0] ADDR_ATTR = 32'hE000EDA0;
   localparam logic [7:0] INSTR_REGION_COUNT = 8'h00;
   localparam logic [7:0] DATA_REGION_COUNT = 8'h08;
   localparam logic [31:0] INFO_VALUE = {8'h00, INSTR_REGION_COUNT, DATA_REGION_COUNT, 8'h00};
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_HANDLER_BIT = 1;
   localparam int CTRL_BG_BIT = 2;
   localparam int SELECT_LSB = 0;
   localparam int BASE_VALID_BIT = 4;
   localparam int BASE_REGION_LSB = 0;
   localparam int BASE_ADDR_LSB = 5;
   localparam int ATTR_XN_BIT = 28;
   localparam int ATTR_AP_LSB = 24;
   localparam int ATTR_S_BIT = 18;
   localparam int ATTR_C_BIT = 17;
   localparam int ATTR_B_BIT = 16;
   localparam int ATTR_SRD_LSB = 8;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_EN_BIT = 0;

   // ----------------------------------------------------------------
   // fixed address windows and map codes
   // ----------------------------------------------------------------
   localparam logic [31:0] SCS_FIRST = 32'hE000E000;
   localparam logic [31:0] SCS_LAST = 32'hE000EFFF;
   localparam logic [31:0] VECTOR_LAST = 32'h000000BF;
   localparam logic [2:0] MAP_CODE = 3'h0;
   localparam logic [2:0] MAP_SRAM = 3'h1;
   localparam logic [2:0] MAP_PERIPH = 3'h2;
   localparam logic [2:0] MAP_RAM_LO = 3'h3;
   localparam logic [2:0] MAP_RAM_HI = 3'h4;
   localparam logic [2:0] MAP_DEV_LO = 3'h5;
   localparam logic [2:0] MAP_DEV_HI = 3'h6;

   // access permission codes
   localparam logic [2:0] AP_NONE = 3'h0;
   localparam logic [2:0] AP_PRIV_RW = 3'h1;
   localparam logic [2:0] AP_USER_RO = 3'h2;
   localparam logic [2:0] AP_FULL = 3'h3;
   localparam logic [2:0] AP_PRIV_RO = 3'h5;
   localparam logic [2:0] AP_RO = 3'h6;
   localparam logic [2:0] AP_RO_ALT = 3'h7;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic xn;
      logic [2:0] ap;
      logic s;
      logic c;
      logic b;
      logic [7:0] srd;
      logic [4:0] size;
      logic en;
      logic [26:0] base;
   } region_s;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic priv;
      logic fetch;
      logic write;
      logic handler;
   } access_s;

   typedef struct packed {
      logic xn;
      logic cacheable;
      logic bufferable;
      logic shareable;
      logic strongly_ordered;
   } mem_attr_s;

   typedef struct packed {
      logic valid;
      logic fault;
      logic access_fault;
      mem_attr_s attr;
   } result_s;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // address bits that select a region of the given size
   function automatic logic [31:0] size_mask(input logic [4:0] size);
      logic [32:0] span;
      span = (33'h1 << ({1'h0, size} + 6'h1)) - 33'h1;
      return ~span[31:0];
   endfunction

   // strongly-ordered memory is always shared and in order
   function automatic mem_attr_s finish_attr(input mem_attr_s a);
      mem_attr_s r;
      r = a;
      r.strongly_ordered = !a.cacheable && !a.bufferable;
      if (r.strongly_ordered) begin
         r.shareable = 1'h1;
      end
      return r;
   endfunction

   function automatic logic is_scs(input logic [31:0] addr);
      return (addr >= SCS_FIRST) && (addr <= SCS_LAST);
   endfunction

   function automatic logic is_vector(input logic [31:0] addr);
      return addr <= VECTOR_LAST;
   endfunction

   // attributes of the default memory map
   function automatic mem_attr_s default_attr(input logic [31:0] addr);
      mem_attr_s a;
      a = '{xn: 1'h1, cacheable: 1'h0, bufferable: 1'h0, shareable: 1'h1,
            strongly_ordered: 1'h0};
      case (addr[31:29])
         MAP_CODE: a = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
         MAP_SRAM, MAP_RAM_LO, MAP_RAM_HI: a = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
         MAP_PERIPH, MAP_DEV_LO, MAP_DEV_HI: a = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
         default: a = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
      endcase
      if (is_scs(addr)) begin
         a.xn = 1'h1;
         a.cacheable = 1'h0;
         a.bufferable = 1'h0;
      end
      return finish_attr(a);
   endfunction

   function automatic logic ap_allows(input logic [2:0] ap, input logic priv,
                                      input logic write);
      case (ap)
         AP_PRIV_RW: return priv;
         AP_USER_RO: return priv || !write;
         AP_FULL: return 1'h1;
         AP_PRIV_RO: return priv && !write;
         AP_RO, AP_RO_ALT: return !write;
         default: return 1'h0;
      endcase
   endfunction

endpackage

/* core/region_match.sv */
`timescale 1ns/10ps

// highest numbered enabled region that covers the address
module region_match (
   input rpu_pkg::region_s [rpu_pkg::NUM_REGIONS-1:0] regions,
   input logic [31:0] addr,
   output logic hit,
   output logic [2:0] hit_index
);

   // ascending scan, so a later region overrides an earlier one
   always_comb begin
      logic [31:0] m;
      m = 32'h0;
      hit = 1'h0;
      hit_index = 3'h0;
      for (int i = 0; i < rpu_pkg::NUM_REGIONS; i++) begin
         m = rpu_pkg::size_mask(regions[i].size);
         if (regions[i].en && ((addr & m) == ({regions[i].base, 5'h00} & m))) begin
            hit = 1'h1;
            hit_index = 3'(i);
         end
      end
   end

endmodule // region_match

/* core/region_protection_unit.sv */
`timescale 1ns/10ps

// Summary of operation
// - eight numbered regions 0..7 plus one background region
// - overlapping enabled regions: highest numbered region supplies attributes
// - background region uses default map attributes, privileged accesses only
// - fetches and data accesses share one region table
// - prohibited access flags a fault to the core instead of completing
// - resolved memory attributes leave alongside every access result
// - strongly-ordered regions are in program order and always shared
// - info register bits 23:16 always read zero
// - info register bits 15:8 read eight, the implemented region count
// - info register bit 0 and other reserved bits read zero
// - control bit 0 enables checking; clear means default map for everyone
// - enabled, bit 2 clear: miss faults; bit 2 set: privileged miss uses default
// - enabled with background on: unprivileged miss gives a memory access fault
// - background ranks as region minus one, any enabled region overrides
// - background bit ignored while checking is off
// - severe-fault and NMI handlers bypass checking unless control bit 1 set
// - with checking on, system control space and vector table skip regions and use the default map
// - system control space is always execute-never and strongly ordered
// - region select bits 2:0 pick the region for base and attribute access
// - base write with valid bit set also loads region select
// - control bits 31:3 ignore writes and read zero
// - base write with valid clear updates selected region, ignores region field
// - every region enable bit resets to zero
module region_protection_unit (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire rpu_pkg::access_s ACC,
   output rpu_pkg::result_s RES
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pready;
      logic slverr;
      logic [31:0] prdata;
      logic ctrl_en;
      logic ctrl_handler;
      logic ctrl_bg;
      logic [2:0] select;
      rpu_pkg::region_s [rpu_pkg::NUM_REGIONS-1:0] regions;
      rpu_pkg::result_s res;
   } state_s;

   state_s s_reg;
   state_s s_next;
   logic hit;
   logic [2:0] hit_index;
   logic checking;
   logic bus_access;
   logic bus_commit;

   // ----------------------------------------------------------------
   // region lookup
   // ----------------------------------------------------------------
   // highest region wins
   region_match u_match (
      .regions(s_reg.regions),
      .addr(ACC.addr),
      .hit(hit),
      .hit_index(hit_index)
   );

   // checking active, handlers bypass unless bit 1 set
   // handler bypass control
   assign checking = s_reg.ctrl_en && (!ACC.handler || s_reg.ctrl_handler);
   assign bus_access = PSEL && PENABLE && !s_reg.pready;
   assign bus_commit = PSEL && PENABLE && s_reg.pready;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // bus slave, register writes and access decision
   always_comb begin
      logic [31:0] rd;
      logic mapped;
      logic [2:0] idx;
      rpu_pkg::region_s r;
      rpu_pkg::mem_attr_s attr;
      logic fault;
      logic afault;
      rd = 32'h0;
      mapped = 1'h1;
      idx = s_reg.select;
      r = s_reg.regions[hit_index];
      attr = rpu_pkg::default_attr(ACC.addr);
      fault = 1'h0;
      afault = 1'h0;
      s_next = s_reg;

      // read mux, reserved bits zero
      case (PADDR)
         rpu_pkg::ADDR_INFO: rd = rpu_pkg::INFO_VALUE;
         rpu_pkg::ADDR_CTRL: rd = {29'h0, s_reg.ctrl_bg, s_reg.ctrl_handler, s_reg.ctrl_en};
         rpu_pkg::ADDR_SELECT: rd = {29'h0, s_reg.select};
         rpu_pkg::ADDR_BASE: begin
            rd = ({s_reg.regions[idx].base, 5'h00}
                  & rpu_pkg::size_mask(s_reg.regions[idx].size))
                 | {29'h0, s_reg.select};
         end
         rpu_pkg::ADDR_ATTR: begin
            rd = {3'h0, s_reg.regions[idx].xn, 1'h0, s_reg.regions[idx].ap, 5'h00,
                  s_reg.regions[idx].s, s_reg.regions[idx].c, s_reg.regions[idx].b,
                  s_reg.regions[idx].srd, 2'h0, s_reg.regions[idx].size,
                  s_reg.regions[idx].en};
         end
         default: mapped = 1'h0;
      endcase

      // answer one cycle into the access phase
      s_next.pready = 1'h0;
      if (bus_access) begin
         s_next.pready = 1'h1;
         s_next.prdata = PWRITE ? 32'h0 : rd;
         s_next.slverr = !mapped;
      end

      // writes take effect at the edge that sees pready
      if (bus_commit && PWRITE) begin
         case (PADDR)
            rpu_pkg::ADDR_CTRL: begin
               s_next.ctrl_en = PWDATA[rpu_pkg::CTRL_ENABLE_BIT];
               s_next.ctrl_handler = PWDATA[rpu_pkg::CTRL_HANDLER_BIT];
               s_next.ctrl_bg = PWDATA[rpu_pkg::CTRL_BG_BIT];
            end
            rpu_pkg::ADDR_SELECT: begin
               s_next.select = PWDATA[rpu_pkg::SELECT_LSB +: 3];
            end
            rpu_pkg::ADDR_BASE: begin
               if (PWDATA[rpu_pkg::BASE_VALID_BIT]) begin
                  idx = PWDATA[rpu_pkg::BASE_REGION_LSB +: 3];
                  s_next.select = idx;
               end
               s_next.regions[idx].base = PWDATA[rpu_pkg::BASE_ADDR_LSB +: 27];
            end
            rpu_pkg::ADDR_ATTR: begin
               s_next.regions[idx].xn = PWDATA[rpu_pkg::ATTR_XN_BIT];
               s_next.regions[idx].ap = PWDATA[rpu_pkg::ATTR_AP_LSB +: 3];
               s_next.regions[idx].s = PWDATA[rpu_pkg::ATTR_S_BIT];
               s_next.regions[idx].c = PWDATA[rpu_pkg::ATTR_C_BIT];
               s_next.regions[idx].b = PWDATA[rpu_pkg::ATTR_B_BIT];
               s_next.regions[idx].srd = PWDATA[rpu_pkg::ATTR_SRD_LSB +: 8];
               s_next.regions[idx].size = PWDATA[rpu_pkg::ATTR_SIZE_LSB +: 5];
               s_next.regions[idx].en = PWDATA[rpu_pkg::ATTR_EN_BIT];
            end
            default: s_next.select = s_reg.select;
         endcase
      end

      // access decision, one shared table for fetch and data
      // unified lookup
      if (!checking) begin
         fault = ACC.fetch && attr.xn;
      end else if (rpu_pkg::is_scs(ACC.addr) || rpu_pkg::is_vector(ACC.addr)) begin
         fault = ACC.fetch && attr.xn;
      end else if (hit) begin
         attr = rpu_pkg::finish_attr('{xn: r.xn, cacheable: r.c, bufferable: r.b,
                                       shareable: r.s, strongly_ordered: 1'h0});
         fault = !rpu_pkg::ap_allows(r.ap, ACC.priv, ACC.write) || (ACC.fetch && r.xn);
      end else if (s_reg.ctrl_bg && ACC.priv) begin
         fault = ACC.fetch && attr.xn;
      end else begin
         fault = 1'h1;
         afault = s_reg.ctrl_bg && !ACC.priv;
      end

      // control space stays execute-never, strongly ordered
      if (rpu_pkg::is_scs(ACC.addr)) begin
         attr = rpu_pkg::default_attr(ACC.addr);
      end

      s_next.res.valid = ACC.valid;
      s_next.res.fault = ACC.valid && fault;
      s_next.res.access_fault = ACC.valid && afault;
      s_next.res.attr = attr;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // regions disabled at reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flip-flops
   assign PRDATA = s_reg.prdata;
   assign PREADY = s_reg.pready;
   assign PSLVERR = s_reg.slverr;
   assign RES = s_reg.res;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   a_info_word: assert property (
      (PREADY && PSEL && !PWRITE && PADDR == rpu_pkg::ADDR_INFO) |-> PRDATA == 32'h00000800
   ) else $error("info register read value wrong");

   a_info_zero: assert property (
      (PREADY && PSEL && !PWRITE && PADDR == rpu_pkg::ADDR_INFO)
      |-> (PRDATA[23:16] == 8'h00 && PRDATA[0] == 1'h0)
   ) else $error("info register zero fields not zero");

   a_ctrl_reserved: assert property (
      (PREADY && PSEL && !PWRITE && PADDR == rpu_pkg::ADDR_CTRL) |-> PRDATA[31:3] == 29'h0
   ) else $error("control reserved bits not zero");

   a_pready_pulse: assert property (
      (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY
   ) else $error("ready not a single cycle answer");

   a_valid_follow: assert property (
      ACC.valid |=> RES.valid
   ) else $error("access result not produced next cycle");

   a_off_default: assert property (
      (ACC.valid && !s_reg.ctrl_en && !ACC.fetch) |=> !RES.fault
   ) else $error("data access faulted with checking off");

   a_scs_attr: assert property (
      (ACC.valid && rpu_pkg::is_scs(ACC.addr)) |=> (RES.attr.xn && RES.attr.strongly_ordered)
   ) else $error("control space lost execute-never or ordering");

   a_miss_fault: assert property (
      (ACC.valid && checking && !hit && !s_reg.ctrl_bg && !rpu_pkg::is_scs(ACC.addr)
       && !rpu_pkg::is_vector(ACC.addr)) |=> (RES.fault && !RES.access_fault)
   ) else $error("region miss did not fault");

   a_user_miss: assert property (
      (ACC.valid && checking && !hit && s_reg.ctrl_bg && !ACC.priv
       && !rpu_pkg::is_scs(ACC.addr) && !rpu_pkg::is_vector(ACC.addr))
      |=> (RES.fault && RES.access_fault)
   ) else $error("unprivileged background miss not flagged");

   a_select_load: assert property (
      (bus_commit && PWRITE && PADDR == rpu_pkg::ADDR_BASE && PWDATA[rpu_pkg::BASE_VALID_BIT])
      |=> s_reg.select == $past(PWDATA[2:0])
   ) else $error("base write with valid did not load select");

   a_so_shared: assert property (
      RES.attr.strongly_ordered |-> (RES.attr.shareable && !RES.attr.cacheable)
   ) else $error("strongly ordered result not shared");

   a_bg_ignored: assert property (
      (ACC.valid && !s_reg.ctrl_en) |=> RES.attr == rpu_pkg::default_attr($past(ACC.addr))
   ) else $error("checking off but attributes not from default map");

   a_bg_priv: assert property (
      (ACC.valid && checking && !hit && s_reg.ctrl_bg && ACC.priv && !ACC.fetch)
      |=> (!RES.fault && RES.attr == rpu_pkg::default_attr($past(ACC.addr)))
   ) else $error("privileged background access not on default map");

   a_handler_bypass: assert property (
      (ACC.valid && ACC.handler && !s_reg.ctrl_handler && !ACC.fetch)
      |=> (!RES.fault && RES.attr == rpu_pkg::default_attr($past(ACC.addr)))
   ) else $error("handler access not bypassed");

   a_handler_check: assert property (
      (ACC.valid && ACC.handler && s_reg.ctrl_en && s_reg.ctrl_handler && !hit
       && !s_reg.ctrl_bg && !rpu_pkg::is_scs(ACC.addr) && !rpu_pkg::is_vector(ACC.addr))
      |=> RES.fault
   ) else $error("handler access not checked with bit 1 set");

   a_space_allowed: assert property (
      (ACC.valid && checking && !ACC.fetch
       && (rpu_pkg::is_scs(ACC.addr) || rpu_pkg::is_vector(ACC.addr))) |=> !RES.fault
   ) else $error("control space or vector table access faulted");

   a_region_attr: assert property (
      (ACC.valid && checking && hit && !rpu_pkg::is_scs(ACC.addr)
       && !rpu_pkg::is_vector(ACC.addr))
      |=> (RES.attr.xn == $past(s_reg.regions[hit_index].xn)
           && RES.attr.cacheable == $past(s_reg.regions[hit_index].c)
           && RES.attr.bufferable == $past(s_reg.regions[hit_index].b))
   ) else $error("hit region attributes not exported");

   a_fetch_xn: assert property (
      (ACC.valid && ACC.fetch && checking && hit && s_reg.regions[hit_index].xn
       && !rpu_pkg::is_scs(ACC.addr) && !rpu_pkg::is_vector(ACC.addr)) |=> RES.fault
   ) else $error("fetch from execute-never region not faulted");

   a_fault_valid: assert property (
      (RES.fault || RES.access_fault) |-> RES.valid
   ) else $error("fault flagged without an access");

   a_afault_sub: assert property (
      RES.access_fault |-> RES.fault
   ) else $error("access fault flagged without fault");

   a_ctrl_store: assert property (
      (bus_commit && PWRITE && PADDR == rpu_pkg::ADDR_CTRL)
      |=> (s_reg.ctrl_en == $past(PWDATA[rpu_pkg::CTRL_ENABLE_BIT])
           && s_reg.ctrl_bg == $past(PWDATA[rpu_pkg::CTRL_BG_BIT]))
   ) else $error("control write not stored");

   a_select_keep: assert property (
      (bus_commit && PWRITE && PADDR == rpu_pkg::ADDR_BASE && !PWDATA[rpu_pkg::BASE_VALID_BIT])
      |=> $stable(s_reg.select)
   ) else $error("base write without valid changed select");

   a_select_read: assert property (
      (PREADY && PSEL && !PWRITE && PADDR == rpu_pkg::ADDR_SELECT) |-> PRDATA[31:3] == 29'h0
   ) else $error("region select upper bits not zero");

   a_reset_clear: assert property (
      $rose(RST_N) |-> (!hit && !s_reg.ctrl_en && s_reg.select == 3'h0)
   ) else $error("region or control state not clear after reset");

   c_region_hit: cover property (ACC.valid && checking && hit ##1 !RES.fault);
   c_bg_priv: cover property (ACC.valid && checking && !hit && s_reg.ctrl_bg && ACC.priv);
   c_handler_bypass: cover property (ACC.valid && s_reg.ctrl_en && ACC.handler && !checking);
   c_apb_write: cover property (bus_commit && PWRITE && PADDR == rpu_pkg::ADDR_ATTR);

endmodule // region_protection_unit

/* testbench/core_model.sv */
`timescale 1ns/10ps

// core side: presents one access, then releases the port
module core_model (
   input wire logic clk,
   output rpu_pkg::access_s acc
);
   initial begin
      acc = '0;
   end

   task automatic issue(input logic [31:0] addr, input logic [3:0] kind);
      @(posedge clk);
      acc <= {1'h1, addr, kind};
      @(posedge clk);
      // released port must not show a stale address
      acc <= {1'h0, ~addr, ~kind};
   endtask
endmodule // core_model

/* testbench/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
   localparam logic [3:0] U_RD = 4'h0;
   localparam logic [3:0] U_HND = 4'h1;
   localparam logic [3:0] P_RD = 4'h8;
   localparam logic [3:0] P_FETCH = 4'hC;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   rpu_pkg::access_s acc;
   rpu_pkg::result_s res;
   int failures = 0;
   int checked = 0;

   region_protection_unit i_region_protection_unit (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .ACC(acc), .RES(res));
   core_model i_core_model (.clk(clk), .acc(acc));

   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer: setup, access, hold until pready sampled high
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      input logic err = 1'h0);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      for (n = 0; n < 20 && pready !== 1'h1; n++) begin
         @(posedge clk);
      end
      if (pready !== 1'h1) begin
         failures++;
         print_verdict();
      end
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, err});
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rchk(input logic [31:0] addr, input logic [31:0] exp, input logic err = 1'h0);
      apb(1'h0, addr, 32'h0, err);
      chk(rd, exp);
   endtask

   // result stands one cycle after the access was taken
   task automatic acc_chk(input logic [31:0] addr, input logic [3:0] kind, input logic f,
                          input logic af, input logic [4:0] attr);
      i_core_model.issue(addr, kind);
      @(posedge clk);
      if (f) begin
         chk({29'h0, res[7:5]}, {29'h0, 1'h1, f, af});
      end else begin
         chk({24'h0, res}, {24'h0, 1'h1, f, af, attr});
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rchk(rpu_pkg::ADDR_INFO, 32'h00000800);
      apb(1'h1, rpu_pkg::ADDR_INFO, 32'hFFFFFFFF);
      rchk(rpu_pkg::ADDR_INFO, 32'h00000800);
      rchk(rpu_pkg::ADDR_CTRL, 32'h0);
      rchk(rpu_pkg::ADDR_ATTR, 32'h0);
      rchk(32'hE000EDA4, 32'h0, 1'h1);
   endtask

   task automatic t_regs();
      int i;
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'hFFFFFFFF);
      rchk(rpu_pkg::ADDR_CTRL, 32'h7);
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h0);
      for (i = 0; i < 8; i++) begin
         apb(1'h1, rpu_pkg::ADDR_SELECT, 32'(i));
         rchk(rpu_pkg::ADDR_SELECT, 32'(i));
      end
      apb(1'h1, rpu_pkg::ADDR_BASE, 32'h20000012);
      rchk(rpu_pkg::ADDR_SELECT, 32'h2);
      apb(1'h1, rpu_pkg::ADDR_BASE, 32'h20001006);
      rchk(rpu_pkg::ADDR_SELECT, 32'h2);
      rchk(rpu_pkg::ADDR_BASE, 32'h20001002);
   endtask

   task automatic t_off();
      acc_chk(32'h20000000, U_RD, 1'h0, 1'h0, 5'h0C);
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h4);
      acc_chk(32'h20000000, U_RD, 1'h0, 1'h0, 5'h0C);
      acc_chk(32'hE000E010, U_RD, 1'h0, 1'h0, 5'h13);
   endtask

   task automatic t_background();
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h1);
      acc_chk(32'h20000000, P_RD, 1'h1, 1'h0, 5'h0);
      acc_chk(32'hE000E010, U_RD, 1'h0, 1'h0, 5'h13);
      acc_chk(32'h00000040, U_RD, 1'h0, 1'h0, 5'h08);
      acc_chk(32'h20000000, U_HND, 1'h0, 1'h0, 5'h0C);
      // handler-protection set only while checking is on
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h3);
      acc_chk(32'h20000000, U_HND, 1'h1, 1'h0, 5'h0);
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h5);
      acc_chk(32'h20000000, P_RD, 1'h0, 1'h0, 5'h0C);
      acc_chk(32'h20000000, U_RD, 1'h1, 1'h1, 5'h0);
   endtask

   task automatic t_regions();
      apb(1'h1, rpu_pkg::ADDR_BASE, 32'h20000012);
      apb(1'h1, rpu_pkg::ADDR_ATTR, 32'h03060017);
      apb(1'h1, rpu_pkg::ADDR_BASE, 32'h20000015);
      apb(1'h1, rpu_pkg::ADDR_ATTR, 32'h11000013);
      rchk(rpu_pkg::ADDR_ATTR, 32'h11000013);
      // regions were enabled with checking already on; background now goes off
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h1);
      acc_chk(32'h20000010, U_RD, 1'h1, 1'h0, 5'h0);
      acc_chk(32'h20000010, P_RD, 1'h0, 1'h0, 5'h13);
      acc_chk(32'h20000010, P_FETCH, 1'h1, 1'h0, 5'h0);
      acc_chk(32'h20000800, U_RD, 1'h0, 1'h0, 5'h0A);
      acc_chk(32'h20001000, U_RD, 1'h1, 1'h0, 5'h0);
      apb(1'h1, rpu_pkg::ADDR_CTRL, 32'h5);
      acc_chk(32'h20000800, P_RD, 1'h0, 1'h0, 5'h0A);
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      t_reset();
      t_regs();
      t_off();
      t_background();
      t_regions();
      print_verdict();
   end
endmodule // tb_top
